// File: rtl/tlic_top.sv
// two-level interrupt controller with apb register file
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module tlic_top
(
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   reset_n,
   // apb slave
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [7:0]             paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   // interrupt source events, one-cycle pulses
   input  wire logic [20:0]            src_event,
   // cpu sequencer status
   input  wire logic                   instr_done,
   input  wire logic                   instr_return_from_irq_instr,
   input  wire logic                   flash_stall,
   // call request and service level
   output tlic_pkg::tlic_call_type     call,
   output logic                        svc_active_hi,
   output logic                        svc_active_lo
);

   // lowest set index, fixed order arbitration
   function automatic logic [4:0] first_set(input logic [20:0] v);
      logic [4:0] idx;
      idx = 5'h00;
      for (int i = 20; i >= 0; i--)
      begin
         if (v[i])
            idx = 5'(i);
      end
      return idx;
   endfunction

   // gather the three registers into one flat source vector
   function automatic logic [20:0] flat(input logic [7:0] a,
                                        input logic [7:0] b,
                                        input logic [7:0] c);
      return {c[5:0], b, a[6:0]};
   endfunction

   // register file state
   logic [7:0]   en_a;              // enable a, bit 7 global
   logic [7:0]   en_b;              // enable b
   logic [7:0]   en_c;              // enable c
   logic [7:0]   pr_a;              // priority a
   logic [7:0]   pr_b;              // priority b
   logic [7:0]   pr_c;              // priority c
   logic [20:0]  pend;              // pending flags
   logic [20:0]  en_dly;            // effective enables, one cycle late
   logic [7:0]   next_en_a;
   logic [7:0]   next_en_b;
   logic [7:0]   next_en_c;
   logic [7:0]   next_pr_a;
   logic [7:0]   next_pr_b;
   logic [7:0]   next_pr_c;
   logic [20:0]  next_pend;
   logic [20:0]  next_en_dly;
   logic [31:0]  next_prdata;
   logic         next_pready;
   logic         next_pslverr;
   // sequencer state
   tlic_pkg::tlic_seq_type  state;
   tlic_pkg::tlic_seq_type  next_state;
   logic [2:0]              cnt;        // long call cycles left
   logic [2:0]              next_cnt;
   tlic_pkg::tlic_call_type next_call;
   logic                    next_act_hi;
   logic                    next_act_lo;
   // decode helpers
   logic [20:0]  req_all;           // enabled pending sources
   logic [20:0]  req_hi;            // high level requests
   logic [20:0]  req_lo;            // low level requests
   logic         take_hi;           // high request may be served
   logic         take_lo;           // low request may be served
   logic         boundary;          // instruction finished, no stall
   logic         grant;             // issue call this cycle
   logic         pop;               // return retires one level
   logic [4:0]   sel;               // granted slot
   logic         access;            // apb access cycle, not answered
   logic         wr;                // apb write taking effect

   // apb handshake and read mux
   always_comb
   begin
      access       = psel && penable && !pready;
      wr           = psel && penable && pready && pwrite;
      next_pready  = access;
      next_pslverr = 1'b0;
      next_prdata  = prdata;
      if (access)
      begin
         next_prdata = 32'h0000_0000;
         case (paddr)
            tlic_pkg::OFS_ENABLE_A: next_prdata[7:0] = en_a;
            tlic_pkg::OFS_ENABLE_B: next_prdata[7:0] = en_b;
            tlic_pkg::OFS_ENABLE_C: next_prdata[7:0] = en_c;
            tlic_pkg::OFS_PRIO_A:   next_prdata[7:0] = pr_a;
            tlic_pkg::OFS_PRIO_B:   next_prdata[7:0] = pr_b;
            tlic_pkg::OFS_PRIO_C:   next_prdata[7:0] = pr_c;
            tlic_pkg::OFS_PENDING:  next_prdata[20:0] = pend;
            tlic_pkg::OFS_STATUS:
               next_prdata = {23'h00_0000, svc_active_hi, svc_active_lo,
                              state, call.index};
            default: next_prdata = 32'h0000_0000;
         endcase
         // unmapped address answers with error
         if (paddr[7:5] != 3'h0 || paddr[1:0] != 2'h0)
            next_pslverr = 1'b1;
      end
   end

   // request decode, every clock
   always_comb
   begin
      req_all  = pend & en_dly & tlic_pkg::VALID_MASK;
      req_hi   = req_all & flat(pr_a, pr_b, pr_c);
      req_lo   = req_all & ~flat(pr_a, pr_b, pr_c);
      take_hi  = (|req_hi) && !svc_active_hi;
      take_lo  = (|req_lo) && !svc_active_hi && !svc_active_lo;
      sel      = take_hi ? first_set(req_hi) : first_set(req_lo);
      boundary = instr_done && !flash_stall;
      grant    = boundary && !instr_return_from_irq_instr && (take_hi || take_lo)
                 && state != tlic_pkg::SEQ_CALL;
      pop      = boundary && instr_return_from_irq_instr && state != tlic_pkg::SEQ_CALL;
   end

   // register writes and pending flags
   always_comb
   begin
      next_en_a = en_a;
      next_en_b = en_b;
      next_en_c = en_c;
      next_pr_a = pr_a;
      next_pr_b = pr_b;
      next_pr_c = pr_c;
      next_pend = pend;
      if (wr)
      begin
         case (paddr)
            tlic_pkg::OFS_ENABLE_A: next_en_a = pwdata[7:0];
            tlic_pkg::OFS_ENABLE_B: next_en_b = pwdata[7:0];
            tlic_pkg::OFS_ENABLE_C: next_en_c = pwdata[7:0];
            tlic_pkg::OFS_PRIO_A:   next_pr_a = pwdata[7:0];
            tlic_pkg::OFS_PRIO_B:   next_pr_b = pwdata[7:0];
            tlic_pkg::OFS_PRIO_C:   next_pr_c = pwdata[7:0];
            tlic_pkg::OFS_PENDING:  next_pend = pwdata[20:0];
            default:                next_pend = pend;
         endcase
      end
      if (grant)
         next_pend = next_pend
                     & ~((21'h00_0001 << sel) & tlic_pkg::HW_CLEAR_MASK);
      next_pend = (next_pend | src_event) & tlic_pkg::VALID_MASK;
      next_en_dly = en_a[tlic_pkg::GLOBAL_EN_BIT]
                    ? flat(en_a, en_b, en_c) : 21'h00_0000;
   end

   // call sequencer next state
   always_comb
   begin
      next_state  = state;
      next_cnt    = cnt;
      next_call   = call;
      next_call.req = 1'b0;
      next_act_hi = svc_active_hi;
      next_act_lo = svc_active_lo;
      case (state)
         // normal run and one-instruction hold after return
         tlic_pkg::SEQ_RUN, tlic_pkg::SEQ_SKIP:
         begin
            if (grant)
            begin
               next_state       = tlic_pkg::SEQ_CALL;
               next_cnt         = tlic_pkg::LONG_BRANCH_CALL_COUNT;
               next_call.req    = 1'b1;
               next_call.high   = take_hi;
               next_call.index  = sel;
               next_call.vector = tlic_pkg::VECTOR_BASE
                                  + 16'(sel) * tlic_pkg::VECTOR_STEP;
               if (take_hi)
                  next_act_hi = 1'b1;
               else
                  next_act_lo = 1'b1;
            end
            else if (pop)
            begin
               next_state = tlic_pkg::SEQ_SKIP;
               if (svc_active_hi)
                  next_act_hi = 1'b0;
               else
                  next_act_lo = 1'b0;
            end
            else if (boundary)
               next_state = tlic_pkg::SEQ_RUN;
         end
         // long call in progress
         tlic_pkg::SEQ_CALL:
         begin
            next_cnt = cnt - 3'h1;
            if (cnt == 3'h1)
               next_state = tlic_pkg::SEQ_RUN;
         end
         default: next_state = tlic_pkg::SEQ_RUN;
      endcase
   end

   // all registers
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         en_a          <= tlic_pkg::ENABLE_RST;
         en_b          <= tlic_pkg::ENABLE_RST;
         en_c          <= tlic_pkg::ENABLE_RST;
         pr_a          <= tlic_pkg::PRIO_RST;
         pr_b          <= tlic_pkg::PRIO_RST;
         pr_c          <= tlic_pkg::PRIO_RST;
         pend          <= tlic_pkg::PENDING_RST;
         en_dly        <= 21'h00_0000;
         prdata        <= 32'h0000_0000;
         pready        <= 1'b0;
         pslverr       <= 1'b0;
         state         <= tlic_pkg::SEQ_RUN;
         cnt           <= 3'h0;
         call          <= '0;
         svc_active_hi <= 1'b0;
         svc_active_lo <= 1'b0;
      end
      else
      begin
         en_a          <= next_en_a;
         en_b          <= next_en_b;
         en_c          <= next_en_c;
         pr_a          <= next_pr_a;
         pr_b          <= next_pr_b;
         pr_c          <= next_pr_c;
         pend          <= next_pend;
         en_dly        <= next_en_dly;
         prdata        <= next_prdata;
         pready        <= next_pready;
         pslverr       <= next_pslverr;
         state         <= next_state;
         cnt           <= next_cnt;
         call          <= next_call;
         svc_active_hi <= next_act_hi;
         svc_active_lo <= next_act_lo;
      end
   end

   // checks on the sequencer and flags
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   AST_EVENT_SETS: assert property (
      |(src_event & tlic_pkg::VALID_MASK) |=>
      (pend & $past(src_event & tlic_pkg::VALID_MASK))
      == $past(src_event & tlic_pkg::VALID_MASK))
      else $error("source event did not set pending flag");
   AST_GLOBAL_GATE: assert property (
      call.req |-> $past(en_a[tlic_pkg::GLOBAL_EN_BIT], 2))
      else $error("call issued with global enable clear");
   AST_AT_BOUNDARY: assert property (
      call.req |-> $past(instr_done) && !$past(flash_stall)
                   && !$past(instr_return_from_irq_instr))
      else $error("call issued off instruction boundary");
   AST_CALL_SPAN: assert property (
      call.req |=> !call.req [*5])
      else $error("call overlaps running long call");
   AST_SKIP_ONE: assert property (
      pop |=> !call.req ##0 state == tlic_pkg::SEQ_SKIP)
      else $error("call taken directly after return");
   AST_NO_PREEMPT_HI: assert property (
      call.req |-> !$past(svc_active_hi))
      else $error("high routine preempted");
   AST_LO_BLOCKS: assert property (
      call.req && $past(svc_active_lo) |-> call.high)
      else $error("equal level request preempted low routine");
   AST_NO_RESERVED: assert property (
      call.req |-> tlic_pkg::VALID_MASK[call.index]
                   && call.vector == tlic_pkg::VECTOR_BASE
                   + 16'(call.index) * tlic_pkg::VECTOR_STEP)
      else $error("bad slot or vector on call");
   AST_HW_CLEAR: assert property (
      call.req && tlic_pkg::HW_CLEAR_MASK[call.index]
      && !(|($past(src_event) & (21'h00_0001 << call.index)))
      && !$past(wr)
      |-> !pend[call.index])
      else $error("auto clear flag still set after vectoring");

   // main scenarios
   COV_LOW_CALL: cover property (call.req && !call.high);
   COV_PREEMPT:  cover property (call.req && call.high && $past(svc_active_lo));
   COV_REENTER:  cover property (pop ##1 boundary [*1] ##1 call.req);
   COV_STALL:    cover property (flash_stall && |req_all);

endmodule

// File: rtl/tlic_pkg.sv
// shared constants and types of the two-level interrupt controller
package tlic_pkg;
   // source count and index width
   localparam int NUM_SRC = 21;
   localparam int IDX_W   = 5;
   // slots that exist; slots 8 and 17 are reserved and never requested
   localparam logic [20:0] VALID_MASK    = 21'h1D_FEFF;
   // sources whose pending flag hardware clears on vectoring
   localparam logic [20:0] HW_CLEAR_MASK = 21'h00_000F;
   // register byte offsets on the apb bus
   localparam logic [7:0] OFS_ENABLE_A = 8'h00;
   localparam logic [7:0] OFS_ENABLE_B = 8'h04;
   localparam logic [7:0] OFS_ENABLE_C = 8'h08;
   localparam logic [7:0] OFS_PRIO_A   = 8'h0C;
   localparam logic [7:0] OFS_PRIO_B   = 8'h10;
   localparam logic [7:0] OFS_PRIO_C   = 8'h14;
   localparam logic [7:0] OFS_PENDING  = 8'h18;
   localparam logic [7:0] OFS_STATUS   = 8'h1C;
   // field positions
   localparam int GLOBAL_EN_BIT = 7;
   // reset values
   localparam logic [7:0]  ENABLE_RST  = 8'h00;
   localparam logic [7:0]  PRIO_RST    = 8'h00;
   localparam logic [20:0] PENDING_RST = 21'h00_0000;
   // service address table: base plus fixed step per slot
   localparam logic [15:0] VECTOR_BASE = 16'h0003;
   localparam logic [15:0] VECTOR_STEP = 16'h0008;
   // timing counts in system clocks
   localparam int DETECT_CYCLES = 1;
   localparam int LONG_BRANCH_CALL_CYCLES  = 5;
   localparam int MIN_RESPONSE  = DETECT_CYCLES + LONG_BRANCH_CALL_CYCLES;
   localparam logic [2:0] LONG_BRANCH_CALL_COUNT = 3'(LONG_BRANCH_CALL_CYCLES);
   // call request to the cpu sequencer
   typedef struct packed
   {
      logic              req;
      logic              high;
      logic [IDX_W-1:0]  index;
      logic [15:0]       vector;
   } tlic_call_type;
   // call sequencer states
   typedef enum logic [1:0] {SEQ_RUN, SEQ_CALL, SEQ_SKIP} tlic_seq_type;
endpackage

// File: testbench/tlic_cpu_model.sv
// cpu sequencer model that marks instruction boundaries
`timescale 1ns/1ps
module tlic_cpu_model
(
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    reset_n,
   // call request from the controller
   input  wire tlic_pkg::tlic_call_type call,
   // commands from the testbench
   input  wire logic [3:0]              instr_len,
   input  wire logic                    return_from_irq_instr_cmd,
   input  wire logic                    stall_cmd,
   // boundary status to the controller
   output logic                         instr_done,
   output logic                         instr_return_from_irq_instr,
   output logic                         flash_stall
);
   logic [3:0] cnt;       // cycles into the current instruction
   logic [2:0] hold;      // long call cycles still to run
   logic       return_from_irq_instr_pend; // next boundary is a return
   logic       run;       // sequencer advancing this cycle
   assign run = reset_n && !stall_cmd && !call.req && hold == 3'h0;
   assign instr_done = run && cnt == instr_len - 4'h1;
   assign instr_return_from_irq_instr = instr_done && return_from_irq_instr_pend;
   assign flash_stall = stall_cmd;
   // instruction counter, call hold, return marker
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         cnt       <= 4'h0;
         hold      <= 3'h0;
         return_from_irq_instr_pend <= 1'b0;
      end
      else
      begin
         // return asked for by software
         if (return_from_irq_instr_cmd)
            return_from_irq_instr_pend <= 1'b1;
         else if (instr_return_from_irq_instr)
            return_from_irq_instr_pend <= 1'b0;
         // four more call cycles after the pulse
         if (call.req)
            hold <= 3'h4;
         else if (hold != 3'h0)
            hold <= hold - 3'h1;
         // restart count at each boundary or hold
         if (instr_done || !run)
            cnt <= 4'h0;
         else
            cnt <= cnt + 4'h1;
      end
   end
endmodule

// File: testbench/testbench.sv
// self-checking testbench of the interrupt controller
`timescale 1ns/1ps
module testbench;
   logic                    clk, reset_n;      // clock and reset
   logic                    psel, penable;     // apb control
   logic                    pwrite, pready;    // apb direction, ready
   logic                    pslverr;           // apb error
   logic [7:0]              paddr;             // apb address
   logic [31:0]             pwdata, prdata;    // apb data
   logic [20:0]             src_event;         // source pulses
   logic                    instr_done;        // instruction boundary
   logic                    instr_return_from_irq_instr;        // boundary is a return
   logic                    flash_stall;       // cpu stalled
   tlic_pkg::tlic_call_type call;              // call request
   logic                    svc_hi, svc_lo;    // routine levels
   logic [3:0]              instr_len;         // model instruction size
   logic                    return_from_irq_instr_cmd;          // ask for a return
   logic                    stall_cmd;         // ask for a stall
   logic [15:0]             cyc;               // timeout counter
   logic [7:0]              n_calls;           // call pulses seen
   logic [7:0]              since_return_from_irq_instr;        // clocks since return
   logic [3:0]              dn;                // boundaries since return
   logic [31:0]             rd;                // last read data
   logic                    er;                // last error flag
   int                      err_count;         // mismatches
   int                      n_checks;          // comparisons
   // device under test
   tlic_top u_dut (.clk(clk), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .src_event(src_event), .instr_done(instr_done),
      .instr_return_from_irq_instr(instr_return_from_irq_instr), .flash_stall(flash_stall), .call(call),
      .svc_active_hi(svc_hi), .svc_active_lo(svc_lo));
   // cpu side model
   tlic_cpu_model u_cpu (.clk(clk), .reset_n(reset_n), .call(call),
      .instr_len(instr_len), .return_from_irq_instr_cmd(return_from_irq_instr_cmd), .stall_cmd(stall_cmd),
      .instr_done(instr_done), .instr_return_from_irq_instr(instr_return_from_irq_instr),
      .flash_stall(flash_stall));
   // compare and count
   task automatic chk(input string w, input logic [31:0] s,
                      input logic [31:0] e);
      n_checks++;
      if (s !== e)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", w, e, s);
      end
   endtask
   // counts, verdict, end of run
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // one apb transfer after an idle edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // register write
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   // register read and compare
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk("read data", rd, e);
   endtask
   // wait for a call pulse and check its fields
   task automatic wait_call(input logic [4:0] i, input logic h);
      int k;
      k = 0;
      @(posedge clk);
      while (call.req !== 1'b1 && k < 40)
      begin
         @(posedge clk);
         k++;
      end
      chk("call pulse", 32'(call.req), 32'h0000_0001);
      chk("call index", 32'(call.index), 32'(i));
      chk("call level", 32'(call.high), 32'(h));
      chk("call vector", 32'(call.vector),
          32'(tlic_pkg::VECTOR_BASE + tlic_pkg::VECTOR_STEP * i));
   endtask
   // no call pulse over n clocks
   task automatic no_call(input int n);
      logic [7:0] c0;
      c0 = n_calls;
      repeat (n) @(posedge clk);
      chk("no call", 32'(n_calls - c0), 32'h0000_0000);
   endtask
   // return from routine, wait for its boundary
   task automatic return_from_irq_instr;
      @(posedge clk);
      return_from_irq_instr_cmd <= 1'b1;
      @(posedge clk);
      return_from_irq_instr_cmd <= 1'b0;
      @(posedge clk);
      while (!(instr_done === 1'b1 && instr_return_from_irq_instr === 1'b1))
         @(posedge clk);
   endtask
   // clock, 50 ns period
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // cycle, call and boundary counters, hang guard
   always @(posedge clk)
   begin
      cyc <= cyc + 16'h0001;
      if (call.req === 1'b1)
         n_calls <= n_calls + 8'h01;
      if (instr_done && instr_return_from_irq_instr)
      begin
         since_return_from_irq_instr <= 8'h00;
         dn         <= 4'h0;
      end
      else
      begin
         since_return_from_irq_instr <= since_return_from_irq_instr + 8'h01;
         dn         <= dn + 4'(instr_done);
      end
      if (cyc == 16'h1770)
      begin
         err_count++;
         report_and_stop();
      end
   end
   // main sequence
   initial
   begin
      {psel, penable, pwrite, return_from_irq_instr_cmd, stall_cmd} = 5'h00;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      src_event = 21'h00_0000;
      instr_len = 4'h1;
      {cyc, n_calls, since_return_from_irq_instr, dn} = 36'h0_0000_0000;
      err_count = 0;
      n_checks = 0;
      reset_n = 1'b0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      for (int i = 0; i < 7; i++)
         rdc(8'(4 * i), 32'h0000_0000);
      rdc(8'h20, 32'h0000_0000);
      chk("slave error", 32'(er), 32'h0000_0001);
      // disabled source only records its flag
      @(posedge clk);
      src_event <= 21'h00_0002;
      @(posedge clk);
      src_event <= 21'h00_0000;
      no_call(20);
      rdc(tlic_pkg::OFS_PENDING, 32'h0000_0002);
      wr(tlic_pkg::OFS_ENABLE_A, 32'h0000_0002);
      no_call(10);
      wr(tlic_pkg::OFS_ENABLE_A, 32'h0000_0082);
      wait_call(5'h01, 1'b0);
      chk("low active", 32'(svc_lo), 32'h0000_0001);
      rdc(tlic_pkg::OFS_PENDING, 32'h0000_0000);
      // high source preempts the low routine
      wr(tlic_pkg::OFS_PRIO_A, 32'h0000_0004);
      wr(tlic_pkg::OFS_ENABLE_A, 32'h0000_0086);
      wr(tlic_pkg::OFS_PENDING, 32'h0000_0004);
      wait_call(5'h02, 1'b1);
      chk("high active", 32'(svc_hi), 32'h0000_0001);
      // high routine blocks another high request
      wr(tlic_pkg::OFS_PRIO_A, 32'h0000_000C);
      wr(tlic_pkg::OFS_ENABLE_A, 32'h0000_008E);
      wr(tlic_pkg::OFS_PENDING, 32'h0000_0008);
      no_call(20);
      return_from_irq_instr();
      wait_call(5'h03, 1'b1);
      chk("boundaries", 32'(dn), 32'h0000_0001);
      // low routine blocks a low request
      return_from_irq_instr();
      wr(tlic_pkg::OFS_ENABLE_A, 32'h0000_0092);
      wr(tlic_pkg::OFS_PENDING, 32'h0000_0010);
      no_call(20);
      return_from_irq_instr();
      wait_call(5'h04, 1'b0);
      chk("boundaries", 32'(dn), 32'h0000_0001);
      // flag left set re-enters after a long instruction
      @(posedge clk);
      instr_len <= 4'h8;
      return_from_irq_instr();
      wait_call(5'h04, 1'b0);
      chk("latency", 32'(since_return_from_irq_instr), 32'h0000_0008);
      @(posedge clk);
      instr_len <= 4'h1;
      wr(tlic_pkg::OFS_PENDING, 32'h0000_0000);
      return_from_irq_instr();
      no_call(20);
      // same cycle arbitration
      wr(tlic_pkg::OFS_PRIO_A, 32'h0000_0040);
      wr(tlic_pkg::OFS_ENABLE_A, 32'h0000_00F0);
      wr(tlic_pkg::OFS_PENDING, 32'h0000_0070);
      wait_call(5'h06, 1'b1);
      wr(tlic_pkg::OFS_PENDING, 32'h0000_0030);
      return_from_irq_instr();
      wait_call(5'h04, 1'b0);
      wr(tlic_pkg::OFS_PENDING, 32'h0000_0000);
      return_from_irq_instr();
      // flash stall delays service
      @(posedge clk);
      stall_cmd <= 1'b1;
      wr(tlic_pkg::OFS_PENDING, 32'h0000_0010);
      no_call(15);
      @(posedge clk);
      stall_cmd <= 1'b0;
      wait_call(5'h04, 1'b0);
      wr(tlic_pkg::OFS_PENDING, 32'h0000_0000);
      return_from_irq_instr();
      // upper registers: reserved slots dropped, slot 18 high
      wr(tlic_pkg::OFS_ENABLE_B, 32'h0000_0002);
      wr(tlic_pkg::OFS_ENABLE_C, 32'h0000_000C);
      wr(tlic_pkg::OFS_PRIO_C, 32'h0000_0008);
      wr(tlic_pkg::OFS_PENDING, 32'h0006_0100);
      wait_call(5'h12, 1'b1);
      rdc(tlic_pkg::OFS_PENDING, 32'h0004_0000);
      rdc(tlic_pkg::OFS_ENABLE_C, 32'h0000_000C);
      wr(tlic_pkg::OFS_PENDING, 32'h0000_0000);
      return_from_irq_instr();
      no_call(20);
      wr(tlic_pkg::OFS_PRIO_B, 32'h0000_00A5);
      rdc(tlic_pkg::OFS_PRIO_B, 32'h0000_00A5);
      // software pads the enable clear with a two-cycle instruction
      @(posedge clk);
      instr_len <= 4'h2;
      // cleared enable reads back zero
      wr(tlic_pkg::OFS_ENABLE_A, 32'h0000_0000);
      rdc(tlic_pkg::OFS_ENABLE_A, 32'h0000_0000);
      report_and_stop();
   end
endmodule
